// file: design/sbba_top.sv
// Serial bus byte access engine: link clock framing logic and register file instance
`timescale 1ns/1ps

module sbba_top (
   // Bridge clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Link clock
   input  wire logic       linkClock,
   // Reset pins
   input  wire logic       pciResetN,
   input  wire logic       globalResetPinN,
   input  wire logic       powerOnReset,
   // Configuration access
   input  wire logic [7:0] cfgAddr,
   input  wire logic       cfgWrEn,
   input  wire logic [7:0] cfgWrData,
   output logic      [7:0] cfgRdData,
   // Serial clock pin, open drain
   input  wire logic       sclIn,
   output logic            sclOut,
   output logic            sclOeN,
   // Serial data pin, open drain
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOeN
);

   localparam int TICK_W = sbba_pkg::TICK_W;
   localparam logic [TICK_W-1:0] RELOAD_NORMAL = TICK_W'(sbba_pkg::QTR_NORMAL_CYC - 1);
   localparam logic [TICK_W-1:0] RELOAD_TEST   = TICK_W'(sbba_pkg::QTR_TEST_CYC - 1);

   typedef struct packed {
      logic                     rstS1;
      logic                     rstS2;
      logic                     reqS1;
      logic                     reqS2;
      logic                     reqSeen;
      logic                     sdaS1;
      logic                     sdaS2;
      logic                     sclS1;
      logic                     sclS2;
      sbba_pkg::sbba_state_type state;
      sbba_pkg::sbba_phase_type phase;
      logic [1:0]               quarter;
      logic [3:0]               bitIdx;
      logic [TICK_W-1:0]        tick;
      logic [7:0]               shift;
      logic                     smp;
      logic                     curRead;
      logic [6:0]               slave;
      logic                     cmdRead;
      logic [7:0]               word;
      logic [7:0]               data;
      logic                     protSel;
      logic                     speedup;
      logic [7:0]               rxByte;
      logic                     rxErr;
      logic                     doneTgl;
      logic                     sclLvl;
      logic                     sdaLvl;
   } sbba_link_type;

   sbba_link_type     q;
   sbba_link_type     d;
   logic              launchTgl;
   logic [7:0]        launchTarget;
   logic [7:0]        launchWord;
   logic [7:0]        launchData;
   logic              launchProtSel;
   logic              launchTest;
   logic              domainRst;
   logic              stall;
   logic              qEnd;
   logic              txMode;
   logic [TICK_W-1:0] reload;

   ////////////////////////////////////////////////////////////////////////////////
   // Bridge clock side
   sbba_regs u_regs (
      .clock           (clock),
      .sys_rst         (sys_rst),
      .pciResetN       (pciResetN),
      .globalResetPinN (globalResetPinN),
      .powerOnReset    (powerOnReset),
      .cfgAddr         (cfgAddr),
      .cfgWrEn         (cfgWrEn),
      .cfgWrData       (cfgWrData),
      .cfgRdData       (cfgRdData),
      .launchTgl       (launchTgl),
      .launchTarget    (launchTarget),
      .launchWord      (launchWord),
      .launchData      (launchData),
      .launchProtSel   (launchProtSel),
      .launchTest      (launchTest),
      .domainRst       (domainRst),
      .doneTgl         (q.doneTgl),
      .rxByte          (q.rxByte),
      .rxErr           (q.rxErr)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Link clock side
   always_comb begin
      d = q;
      d.rstS1 = domainRst;
      d.rstS2 = q.rstS1;
      d.reqS1 = launchTgl;
      d.reqS2 = q.reqS1;
      d.sdaS1 = sdaIn;
      d.sdaS2 = q.sdaS1;
      d.sclS1 = sclIn;
      d.sclS2 = q.sclS1;
      txMode = !(q.phase == sbba_pkg::PH_DATA && q.curRead);
      reload = q.speedup ? RELOAD_TEST : RELOAD_NORMAL;
      // A slave holding the clock low stretches the high phase
      stall = (q.state != sbba_pkg::ST_IDLE) && (q.state != sbba_pkg::ST_FINISH)
              && (q.quarter == sbba_pkg::Q1) && !q.sclS2;
      qEnd = (q.tick == '0) && !stall;
      if (q.tick != '0) begin
         d.tick = q.tick - TICK_W'(1);
      end else if (!stall) begin
         d.tick = reload;
      end
      if (qEnd) begin
         d.quarter = q.quarter + 2'h1;
      end
      case (q.state)
         sbba_pkg::ST_IDLE: begin
            d.tick = '0;
            d.quarter = sbba_pkg::Q0;
            if (q.reqS2 != q.reqSeen) begin
               // Launch values are stable while the bridge side is busy
               d.reqSeen = q.reqS2;
               d.slave = launchTarget[7:1];
               d.cmdRead = launchTarget[sbba_pkg::TGT_DIR_BIT];
               d.word = launchWord;
               d.data = launchData;
               d.protSel = launchProtSel;
               d.speedup = launchTest;
               // Word address mode opens every transfer with a write address
               d.curRead = launchTarget[sbba_pkg::TGT_DIR_BIT] && launchProtSel;
               d.shift = {launchTarget[7:1],
                          launchTarget[sbba_pkg::TGT_DIR_BIT] && launchProtSel};
               d.phase = sbba_pkg::PH_ADDR;
               d.rxErr = 1'h0;
               d.state = sbba_pkg::ST_START;
            end
         end
         sbba_pkg::ST_START: begin
            if (qEnd && q.quarter == sbba_pkg::Q3) begin
               d.bitIdx = 4'h0;
               d.state = sbba_pkg::ST_BITS;
            end
         end
         sbba_pkg::ST_BITS: begin
            if (qEnd && q.quarter == sbba_pkg::Q2) begin
               d.smp = q.sdaS2;
            end
            if (qEnd && q.quarter == sbba_pkg::Q3) begin
               if (q.bitIdx != sbba_pkg::ACK_IDX) begin
                  d.shift = {q.shift[6:0], q.smp};
                  d.bitIdx = q.bitIdx + 4'h1;
               end else begin
                  d.bitIdx = 4'h0;
                  if (txMode && q.smp) begin
                     d.rxErr = 1'h1;
                     d.state = sbba_pkg::ST_STOP;
                  end else begin
                     case (q.phase)
                        sbba_pkg::PH_ADDR: begin
                           if (q.curRead) begin
                              d.phase = sbba_pkg::PH_DATA;
                           end else if (q.protSel) begin
                              d.phase = sbba_pkg::PH_DATA;
                              d.shift = q.data;
                           end else begin
                              d.phase = sbba_pkg::PH_WORD;
                              d.shift = q.word;
                           end
                        end
                        sbba_pkg::PH_WORD: begin
                           if (q.cmdRead) begin
                              // Repeated start turns the bus round for the read
                              d.phase = sbba_pkg::PH_ADDR;
                              d.curRead = 1'h1;
                              d.shift = {q.slave, 1'h1};
                              d.state = sbba_pkg::ST_START;
                           end else begin
                              d.phase = sbba_pkg::PH_DATA;
                              d.shift = q.data;
                           end
                        end
                        sbba_pkg::PH_DATA: begin
                           if (q.curRead) begin
                              d.rxByte = q.shift;
                           end
                           d.state = sbba_pkg::ST_STOP;
                        end
                        default: begin
                           d.state = sbba_pkg::ST_STOP;
                        end
                     endcase
                  end
               end
            end
         end
         sbba_pkg::ST_STOP: begin
            if (qEnd && q.quarter == sbba_pkg::Q3) begin
               d.state = sbba_pkg::ST_FINISH;
            end
         end
         sbba_pkg::ST_FINISH: begin
            // Results settled earlier, so the toggle alone marks the end
            d.doneTgl = ~q.doneTgl;
            d.state = sbba_pkg::ST_IDLE;
         end
         default: begin
            d.state = sbba_pkg::ST_IDLE;
         end
      endcase
      if (q.rstS2) begin
         d.state = sbba_pkg::ST_IDLE;
         d.phase = sbba_pkg::PH_ADDR;
         d.reqSeen = 1'h0;
         d.doneTgl = 1'h0;
         d.rxErr = 1'h0;
         d.rxByte = sbba_pkg::RST_BYTE;
         d.tick = '0;
         d.quarter = sbba_pkg::Q0;
         d.bitIdx = 4'h0;
         d.speedup = 1'h0;
      end
      // Pin levels follow the next state so they leave straight from flops
      d.sclLvl = 1'h1;
      d.sdaLvl = 1'h1;
      case (d.state)
         sbba_pkg::ST_START: begin
            d.sclLvl = (d.quarter == sbba_pkg::Q0) ? q.sclLvl : (d.quarter != sbba_pkg::Q3);
            d.sdaLvl = (d.quarter == sbba_pkg::Q0) || (d.quarter == sbba_pkg::Q1);
         end
         sbba_pkg::ST_BITS: begin
            d.sclLvl = (d.quarter == sbba_pkg::Q1) || (d.quarter == sbba_pkg::Q2);
            if (!(d.phase == sbba_pkg::PH_DATA && d.curRead) && d.bitIdx != sbba_pkg::ACK_IDX) begin
               d.sdaLvl = d.shift[7];
            end
         end
         sbba_pkg::ST_STOP: begin
            d.sclLvl = (d.quarter != sbba_pkg::Q0);
            d.sdaLvl = (d.quarter == sbba_pkg::Q2) || (d.quarter == sbba_pkg::Q3);
         end
         default: begin
            d.sclLvl = 1'h1;
            d.sdaLvl = 1'h1;
         end
      endcase
   end

   always_ff @(posedge linkClock) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Open drain: drive low with enable low, otherwise release
   assign sclOut = q.sclLvl;
   assign sclOeN = q.sclLvl;
   assign sdaOut = q.sdaLvl;
   assign sdaOeN = q.sdaLvl;

endmodule

// file: design/sbba_pkg.sv
// Constants and types shared by the serial bus byte access block
package sbba_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Register offsets, all registers one byte wide
   localparam logic [7:0] OFS_DATA    = 8'hB0;
   localparam logic [7:0] OFS_WORD    = 8'hB1;
   localparam logic [7:0] OFS_TARGET  = 8'hB2;
   localparam logic [7:0] OFS_CSR     = 8'hB3;
   localparam logic [7:0] RST_BYTE    = 8'h00;

   ////////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int         TGT_DIR_BIT  = 0;
   localparam int         CSR_PROT_BIT = 7;
   localparam int         CSR_BUSY_BIT = 5;
   localparam int         CSR_TEST_BIT = 2;
   localparam int         CSR_ERR_BIT  = 1;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int         SYS_PERIOD_NS  = 10;
   localparam int         LINK_PERIOD_NS = 160;
   localparam longint     NS_PER_SEC     = 64'd1000000000;
   localparam int         SCL_NORMAL_HZ  = 60000;
   localparam int         SCL_TEST_HZ    = 4000000;
   localparam int         QTR_PER_BIT    = 4;
   // Link domain reset pulse must outlast the two stage synchroniser
   localparam int         RST_HOLD_NS    = 4 * LINK_PERIOD_NS;
   localparam int         RST_HOLD_CYC   = (RST_HOLD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam int         HOLD_W         = $clog2(RST_HOLD_CYC + 1);

   // Quarter bit length in link cycles, rounded down, never below one
   function automatic int qtrCycles(input int hz);
      longint c;
      c = NS_PER_SEC / (QTR_PER_BIT * LINK_PERIOD_NS) / hz;
      return (c < 1) ? 1 : int'(c);
   endfunction

   localparam int         QTR_NORMAL_CYC = qtrCycles(SCL_NORMAL_HZ);
   localparam int         QTR_TEST_CYC   = qtrCycles(SCL_TEST_HZ);
   localparam int         TICK_W         = $clog2(QTR_NORMAL_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////////
   // Bit framing
   localparam logic [3:0] ACK_IDX = 4'h8;
   localparam logic [1:0] Q0      = 2'h0;
   localparam logic [1:0] Q1      = 2'h1;
   localparam logic [1:0] Q2      = 2'h2;
   localparam logic [1:0] Q3      = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_START  = 3'h1,
      ST_BITS   = 3'h3,
      ST_STOP   = 3'h2,
      ST_FINISH = 3'h6
   } sbba_state_type;

   typedef enum logic [1:0] {
      PH_ADDR = 2'h0,
      PH_WORD = 2'h1,
      PH_DATA = 2'h3
   } sbba_phase_type;

endpackage

// file: design/sbba_regs.sv
// Register file and reset gathering of the serial bus byte access block, bridge clock domain
`timescale 1ns/1ps
module sbba_regs (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       sys_rst,
   // Reset pins
   input  wire logic       pciResetN,
   input  wire logic       globalResetPinN,
   input  wire logic       powerOnReset,
   // Configuration access
   input  wire logic [7:0] cfgAddr,
   input  wire logic       cfgWrEn,
   input  wire logic [7:0] cfgWrData,
   output logic      [7:0] cfgRdData,
   // Launch toward the link domain
   output logic            launchTgl,
   output logic      [7:0] launchTarget,
   output logic      [7:0] launchWord,
   output logic      [7:0] launchData,
   output logic            launchProtSel,
   output logic            launchTest,
   output logic            domainRst,
   // Result from the link domain
   input  wire logic       doneTgl,
   input  wire logic [7:0] rxByte,
   input  wire logic       rxErr
);

   localparam int HOLD_W = sbba_pkg::HOLD_W;
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(sbba_pkg::RST_HOLD_CYC);

   typedef struct packed {
      logic [2:0]        pinS1;
      logic [2:0]        pinS2;
      logic [HOLD_W-1:0] hold;
      logic              rstOut;
      logic [7:0]        dataByte;
      logic [7:0]        wordByte;
      logic [7:0]        target;
      logic              protSel;
      logic              speedup;
      logic              errFlag;
      logic              busy;
      logic              reqTgl;
      logic              doneS1;
      logic              doneS2;
      logic              doneSeen;
      logic [7:0]        rdData;
   } sbba_regs_type;

   sbba_regs_type q;
   sbba_regs_type d;
   logic          clr;
   logic          wrIdle;
   logic          doneEvt;
   logic          errClr;
   logic          errSet;
   logic [7:0]    csr;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      csr = sbba_pkg::RST_BYTE;
      // Reset pins arrive asynchronously
      d.pinS1 = {~pciResetN, ~globalResetPinN, powerOnReset};
      d.pinS2 = q.pinS1;
      clr = |q.pinS2;
      d.doneS1 = doneTgl;
      d.doneS2 = q.doneS1;
      // Done edges while idle are leftovers of a reset and are dropped
      doneEvt = (q.doneS2 != q.doneSeen) && q.busy;
      d.doneSeen = q.doneS2;
      // Writes while busy are ignored, apart from the error clear, so the link sees stable launch values
      wrIdle = cfgWrEn && !q.busy;
      if (wrIdle && cfgAddr == sbba_pkg::OFS_DATA) begin
         d.dataByte = cfgWrData;
      end
      if (wrIdle && cfgAddr == sbba_pkg::OFS_WORD) begin
         d.wordByte = cfgWrData;
      end
      if (wrIdle && cfgAddr == sbba_pkg::OFS_TARGET) begin
         d.target = cfgWrData;
         d.busy = 1'h1;
         d.reqTgl = ~q.reqTgl;
      end
      if (wrIdle && cfgAddr == sbba_pkg::OFS_CSR) begin
         d.protSel = cfgWrData[sbba_pkg::CSR_PROT_BIT];
         d.speedup = cfgWrData[sbba_pkg::CSR_TEST_BIT];
      end
      errClr = cfgWrEn && cfgAddr == sbba_pkg::OFS_CSR && cfgWrData[sbba_pkg::CSR_ERR_BIT];
      errSet = doneEvt && rxErr;
      d.errFlag = (q.errFlag && !errClr) || errSet;
      if (doneEvt) begin
         d.busy = 1'h0;
         if (q.target[sbba_pkg::TGT_DIR_BIT] && !rxErr) begin
            d.dataByte = rxByte;
         end
      end
      csr[sbba_pkg::CSR_PROT_BIT] = q.protSel;
      csr[sbba_pkg::CSR_BUSY_BIT] = q.busy;
      csr[sbba_pkg::CSR_TEST_BIT] = q.speedup;
      csr[sbba_pkg::CSR_ERR_BIT] = q.errFlag;
      case (cfgAddr)
         sbba_pkg::OFS_DATA:   d.rdData = q.dataByte;
         sbba_pkg::OFS_WORD:   d.rdData = q.wordByte;
         sbba_pkg::OFS_TARGET: d.rdData = q.target;
         sbba_pkg::OFS_CSR:    d.rdData = csr;
         default:              d.rdData = sbba_pkg::RST_BYTE;
      endcase
      // Stretch reset so the slower link clock always sees it
      if (q.hold != '0) begin
         d.hold = q.hold - HOLD_W'(1);
      end
      d.rstOut = (q.hold != '0);
      if (sys_rst || clr) begin
         d.hold = HOLD_LOAD;
         d.rstOut = 1'h1;
         d.dataByte = sbba_pkg::RST_BYTE;
         d.wordByte = sbba_pkg::RST_BYTE;
         d.target = sbba_pkg::RST_BYTE;
         d.protSel = 1'h0;
         d.speedup = 1'h0;
         d.errFlag = 1'h0;
         d.busy = 1'h0;
         d.reqTgl = 1'h0;
      end
      if (sys_rst) begin
         d.pinS1 = '0;
         d.pinS2 = '0;
         d.doneS1 = 1'h0;
         d.doneS2 = 1'h0;
         d.doneSeen = 1'h0;
         d.rdData = sbba_pkg::RST_BYTE;
      end
   end

   always_ff @(posedge clock) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign cfgRdData = q.rdData;
   assign launchTgl = q.reqTgl;
   assign launchTarget = q.target;
   assign launchWord = q.wordByte;
   assign launchData = q.dataByte;
   assign launchProtSel = q.protSel;
   assign launchTest = q.speedup;
   assign domainRst = q.rstOut;

endmodule

// file: dv/sbba_checker.sv
// Port level assertions for the serial bus byte access engine
`timescale 1ns/1ps
module sbba_checker (
   // Clocks and resets
   input wire logic       clock,
   input wire logic       sys_rst,
   input wire logic       linkClock,
   input wire logic       pciResetN,
   input wire logic       globalResetPinN,
   input wire logic       powerOnReset,
   // Configuration access
   input wire logic [7:0] cfgAddr,
   input wire logic       cfgWrEn,
   input wire logic [7:0] cfgRdData,
   // Bus pins
   input wire logic       sclOut,
   input wire logic       sclOeN,
   input wire logic       sdaOut,
   input wire logic       sdaOeN
);
   wire        pinRst = !pciResetN || !globalResetPinN || powerOnReset;
   // Link side resets through a synchroniser, so its pins settle only later
   logic [6:0] settle_q = 7'h00;
   wire        unsettled = settle_q != 7'h7F;
   always @(posedge clock) settle_q <= sys_rst ? 7'h00 : settle_q + 7'(unsettled);
   ////////////////////////////////////////////////////////////////////////////////
   property p_rst_clear;
      @(posedge clock) sys_rst |=> cfgRdData == 8'h00;
   endproperty
   a_rst_clear: assert property (p_rst_clear)
      else $error("read data not cleared by reset");
   property p_pin_clear;
      @(posedge clock) disable iff (sys_rst) pinRst [*6] |-> cfgRdData == 8'h00;
   endproperty
   a_pin_clear: assert property (p_pin_clear)
      else $error("registers not cleared by reset pin");
   property p_busy_set;
      @(posedge clock) disable iff (sys_rst || pinRst)
         cfgWrEn && cfgAddr == sbba_pkg::OFS_TARGET ##2 cfgAddr == sbba_pkg::OFS_CSR
         |=> cfgRdData[sbba_pkg::CSR_BUSY_BIT];
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("busy not shown after launch");
   property p_resv_zero;
      @(posedge clock) disable iff (sys_rst) cfgAddr == sbba_pkg::OFS_CSR
         |=> (cfgRdData & 8'h59) == 8'h00;
   endproperty
   a_resv_zero: assert property (p_resv_zero)
      else $error("reserved status bits not zero");
   property p_scl_pair;
      @(posedge linkClock) disable iff (unsettled) sclOut == sclOeN;
   endproperty
   a_scl_pair: assert property (p_scl_pair)
      else $error("clock pin level and enable differ");
   property p_sda_pair;
      @(posedge linkClock) disable iff (unsettled) sdaOut == sdaOeN;
   endproperty
   a_sda_pair: assert property (p_sda_pair)
      else $error("data pin level and enable differ");
   property p_scl_hold;
      @(posedge linkClock) disable iff (unsettled) $rose(sclOeN) |=> sclOeN;
   endproperty
   a_scl_hold: assert property (p_scl_hold)
      else $error("clock high phase too short");
   property p_stop_idle;
      @(posedge linkClock) disable iff (unsettled)
         $rose(sdaOeN) && sclOeN && $past(sclOeN) |=> sclOeN && sdaOeN;
   endproperty
   a_stop_idle: assert property (p_stop_idle)
      else $error("bus not left idle after stop");
   c_launch: cover property (@(posedge clock) cfgWrEn && cfgAddr == sbba_pkg::OFS_TARGET);
   c_start: cover property (@(posedge linkClock) $fell(sdaOeN) && sclOeN);
   c_pin: cover property (@(posedge clock) pinRst);
endmodule

bind sbba_top sbba_checker i_chk (.clock(clock), .sys_rst(sys_rst), .linkClock(linkClock),
   .pciResetN(pciResetN), .globalResetPinN(globalResetPinN), .powerOnReset(powerOnReset),
   .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgRdData(cfgRdData), .sclOut(sclOut),
   .sclOeN(sclOeN), .sdaOut(sdaOut), .sdaOeN(sdaOeN));

// file: dv/sbba_eeprom_model.sv
// Behavioural serial EEPROM facing the engine on the two wire bus
`timescale 1ns/1ps
module sbba_eeprom_model #(
   parameter logic [6:0] DEV_ADDR = 7'h50  // Arbitrary bench address
) (
   // Resolved bus wires
   input  wire logic scl,
   input  wire logic sda,
   // Answer slowly by holding the clock after each acknowledge
   input  wire logic stretch,
   // Open drain pulls, high pulls the line low
   output logic      sdaLowEn,
   output logic      sclLowEn
);
   logic [7:0] mem [256];
   logic [7:0] ptr;
   logic [7:0] rxB;
   logic       bitV;
   int         cond;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
   end
   // Cond is 1 for a start and 2 for a stop seen while the clock is high
   task automatic getBit();
      @(posedge scl);
      bitV = sda;
      cond = 0;
      fork
         @(negedge scl);
         @(sda) cond = sda ? 2 : 1;
      join_any
      disable fork;
   endtask
   task automatic getByte();
      for (int i = 0; i < 8; i++) begin
         getBit();
         if (cond != 0) return;
         rxB = {rxB[6:0], bitV};
      end
   endtask
   task automatic ackIt();
      sdaLowEn = 1'b1;
      @(negedge scl);
      sdaLowEn = 1'b0;
      if (stretch) begin
         sclLowEn = 1'b1;
         #2000 sclLowEn = 1'b0;
      end
   endtask
   task automatic sendByte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sdaLowEn = !b[i];
         @(negedge scl);
      end
      sdaLowEn = 1'b0;
      getBit();
   endtask
   // First byte after a write address sets the pointer, later ones are stored
   always begin
      sdaLowEn = 1'b0;
      sclLowEn = 1'b0;
      @(negedge sda iff scl === 1'b1);
      cond = 1;
      while (cond == 1) begin
         getByte();
         if (cond == 0 && rxB[7:1] == DEV_ADDR) begin
            ackIt();
            if (rxB[0]) begin
               sendByte(mem[ptr]);
               ptr++;
               cond = 3;
            end else begin
               getByte();
               if (cond == 0) ptr = rxB;
               while (cond == 0) begin
                  ackIt();
                  getByte();
                  if (cond == 0) begin
                     mem[ptr] = rxB;
                     ptr++;
                  end
               end
            end
         end
      end
   end
endmodule

// file: dv/tb_top.sv
// Register level test of the serial bus byte access engine
`timescale 1ns/1ps
module tb_top;
   localparam logic [6:0] DEV  = 7'h50;  // Arbitrary bench address
   localparam logic [7:0] ADAT = sbba_pkg::OFS_DATA;
   localparam logic [7:0] AWRD = sbba_pkg::OFS_WORD;
   localparam logic [7:0] ATGT = sbba_pkg::OFS_TARGET;
   localparam logic [7:0] ACSR = sbba_pkg::OFS_CSR;
   logic       clock = 1'b0, linkClock = 1'b0, sys_rst = 1'b1, stretch = 1'b0;
   logic       pciResetN = 1'b1, globalResetPinN = 1'b1, powerOnReset = 1'b0;
   logic [7:0] cfgAddr = 8'h00, cfgWrData = 8'h00, cfgRdData;
   logic       cfgWrEn = 1'b0, sclOut, sclOeN, sdaOut, sdaOeN, sclLowEn, sdaLowEn;
   int         fail_count = 0, compares = 0;
   real        riseT = 0.0, hiNs = 0.0;
   // Open drain wires with pull-ups
   wire        sclW = sclOeN & ~sclLowEn;
   wire        sdaW = sdaOeN & ~sdaLowEn;
   always #5 clock = ~clock;
   initial begin
      #23;
      forever #80 linkClock = ~linkClock;
   end
   always @(posedge sclOeN) riseT = $realtime;
   always @(negedge sclOeN) hiNs = $realtime - riseT;
   sbba_top i_dut (.clock(clock), .sys_rst(sys_rst), .linkClock(linkClock),
      .pciResetN(pciResetN), .globalResetPinN(globalResetPinN), .powerOnReset(powerOnReset),
      .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .sclIn(sclW), .sclOut(sclOut), .sclOeN(sclOeN), .sdaIn(sdaW), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN));
   sbba_eeprom_model #(.DEV_ADDR(DEV)) i_mdl (.scl(sclW), .sda(sdaW), .stretch(stretch),
      .sdaLowEn(sdaLowEn), .sclLowEn(sclLowEn));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("compares %0d, fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         fail_count++;
         $display("wrong value at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   // Every task starts and ends just after a falling edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cfgAddr = a;
      cfgWrData = d;
      cfgWrEn = 1'b1;
      @(negedge clock) cfgWrEn = 1'b0;
      @(negedge clock);
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
      cfgAddr = a;
      @(negedge clock) chk(cfgRdData, e);
   endtask
   task automatic launch(input logic [7:0] t);
      wr(ATGT, t);
      for (int i = 0; i < 60000; i++) begin
         cfgAddr = ACSR;
         @(negedge clock);
         if (cfgRdData[sbba_pkg::CSR_BUSY_BIT] === 1'b0) return;
      end
      fail_count++;
      $display("wrong value at %0t: engine stays busy", $time);
      give_verdict();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      repeat (100) @(negedge clock);
      for (int a = 0; a < 5; a++) rdChk(ADAT + 8'(a), 8'h00);
      wr(ADAT, 8'h3C);
      wr(AWRD, 8'hC3);
      wr(ACSR, 8'h04);
      wr(ATGT, {DEV, 1'b0});
      wr(AWRD, 8'h11);
      launch({DEV, 1'b0});
      chk(i_mdl.mem[8'hC3], 8'h3C);
      rdChk(AWRD, 8'hC3);
      rdChk(ATGT, {DEV, 1'b0});
      // Test mode clock high: one quarter plus two cycles of clock sync, then one quarter
      chk(8'(int'(hiNs) / 160), 8'h04);
      wr(ADAT, 8'h00);
      launch({DEV, 1'b1});
      rdChk(ADAT, 8'h3C);
      rdChk(ATGT, {DEV, 1'b1});
      stretch = 1'b1;
      wr(ACSR, 8'h84);
      wr(ADAT, 8'h07);
      launch({DEV, 1'b0});
      launch({DEV, 1'b1});
      rdChk(ADAT, 8'h5D);
      chk(i_mdl.mem[8'h07], 8'h5D);
      stretch = 1'b0;
      wr(ACSR, 8'h04);
      launch({7'h51, 1'b1});
      rdChk(ADAT, 8'h5D);
      wr(ACSR, 8'h04);
      rdChk(ACSR, 8'h06);
      wr(ACSR, 8'h02);
      rdChk(ACSR, 8'h00);
      wr(ACSR, 8'h80);
      wr(ADAT, 8'h20);
      launch({DEV, 1'b0});
      chk(8'(int'(hiNs) / 160), 8'h34);
      for (int k = 0; k < 3; k++) begin
         wr(ADAT, 8'hFF);
         wr(AWRD, 8'hFF);
         wr(ACSR, 8'h84);
         pciResetN = (k != 0);
         globalResetPinN = (k != 1);
         powerOnReset = (k == 2);
         repeat (8) @(negedge clock);
         {pciResetN, globalResetPinN, powerOnReset} = 3'b110;
         repeat (100) @(negedge clock);
         for (int a = 0; a < 4; a++) rdChk(ADAT + 8'(a), 8'h00);
      end
      give_verdict();
   end
endmodule
